// ---- design/uas_cycle_timer.sv ----
// Saturating cycle timer that flags LIMIT counting cycles seen since the last clear; cycles without run pause it
`timescale 1ns/1ps
module uas_cycle_timer
  import uas_pkg::*;
#(
  parameter int LIMIT = 4,
  parameter int W = $clog2(LIMIT + 1)
) (
  input wire logic core_clk, // Core clock
  input wire logic rst_n,    // Synchronised reset, active low
  input wire logic run,      // Count this cycle
  input wire logic clear,    // Restart from zero
  output logic done          // Level: LIMIT run cycles seen since last clear
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_done;

  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  // Count up while running, stop at the last value, clear wins
  always_comb begin
    next_cnt = cnt;
    next_done = done;
    if (clear) begin
      next_cnt = '0;
      next_done = 1'b0;
    end else if (run && !done) begin
      if (cnt == LAST) begin
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  // Timer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule

// ---- design/uas_pkg.sv ----
// Shared constants and types for the audio session sequencer
package uas_pkg;
  // Core clock rate in MHz; the board is expected to supply a stable clock
  localparam int CORE_CLK_MHZ = 25;
  // Least continuous bus idle before suspend, in microseconds
  localparam int IDLE_TIME_US = 5000;
  // Internal reset stretch after power-up, in microseconds
  localparam int POR_TIME_US = 700;
  // Cycle counts derived from the times (exact at integer MHz)
  localparam int IDLE_CYC = IDLE_TIME_US * CORE_CLK_MHZ;
  localparam int POR_CYC = POR_TIME_US * CORE_CLK_MHZ;
  // Audio sample width and the bipolar zero code for two's complement
  localparam int SAMPLE_W = 16;
  localparam logic [SAMPLE_W-1:0] BIPOLAR_ZERO_LEVEL = 16'h0000;

  // Playback sequencing states
  typedef enum logic [1:0] {
    PB_IDLE = 2'b00,
    PB_PRIME = 2'b01,
    PB_PLAY = 2'b10,
    PB_DRAIN = 2'b11
  } uas_pb_e;

  // Events from the USB protocol engine, all on core_clk
  typedef struct packed {
    logic configured; // Level: device configured by host
    logic sof;        // Pulse: start-of-frame packet seen
    logic pkt_rx;     // Pulse: a whole 1 ms audio packet stored in the buffer
    logic play_end;   // Pulse: host ended or aborted the playback stream
    logic rec_sel;    // Pulse: interface selection with an operational record setting
    logic rec_zero;   // Pulse: record interface set to zero bandwidth
  } uas_ev_s;
endpackage

// ---- design/uas_session_seq.sv ----
// Playback, record and suspend sequencing of a USB audio function
`timescale 1ns/1ps
module uas_session_seq
  import uas_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int POR_CYCLES = POR_CYC,
  parameter int SW = SAMPLE_W
) (
  input wire logic core_clk,               // Core clock
  input wire logic arst_n,                 // Asynchronous reset, active low
  input wire logic bus_idle_pin,           // Bus line state is idle, from the pins
  input wire uas_ev_s ev,                  // Protocol engine events
  input wire logic buf_empty,              // Playback buffer holds no samples
  input wire logic [SW-1:0] buf_data,      // Sample at the buffer head
  input wire logic dac_tick,               // Pulse: one output sample period
  output logic buf_pop,                    // Pulse: sample taken from the buffer
  output logic [SW-1:0] dac_data,          // Sample toward the converter
  output logic capture_en,                 // Level: record capture running
  output logic suspend_indicator,          // Level: device suspended
  output logic core_rst_n                  // Internal reset released, active low
);
  logic rst_meta;
  logic rst_n;
  logic idle_meta;
  logic idle_sync;
  logic por_done;
  logic idle_done;
  uas_pb_e pb_st;
  uas_pb_e next_pb_st;
  logic next_buf_pop;
  logic [SW-1:0] next_dac_data;
  logic next_capture_en;
  logic next_suspend;
  logic active;

  // Reset release and bus idle synchronisers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
      idle_meta <= 1'b0;
      idle_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
      idle_meta <= bus_idle_pin;
      idle_sync <= idle_meta;
    end
  end

  // Power-up reset stretch, counted on the single core clock
  uas_cycle_timer #(
    .LIMIT(POR_CYCLES)
  ) u_por_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(1'b1),
    .clear(1'b0),
    .done(por_done)
  );

  // Bus idle interval, restarted by any non-idle cycle
  uas_cycle_timer #(
    .LIMIT(IDLE_CYCLES)
  ) u_idle_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(idle_sync),
    .clear(!idle_sync),
    .done(idle_done)
  );

  assign active = por_done && ev.configured;

  // Playback states that hold the output at bipolar zero
  function automatic logic pb_waiting(input uas_pb_e s);
    return s == PB_IDLE || s == PB_PRIME;
  endfunction

  // Playback states that take samples from the buffer
  function automatic logic pb_streaming(input uas_pb_e s);
    return s == PB_PLAY || s == PB_DRAIN;
  endfunction

  // Playback sequencing and output sample path
  always_comb begin
    next_pb_st = pb_st;
    unique case (pb_st)
      PB_IDLE: begin
        if (ev.pkt_rx) next_pb_st = PB_PRIME;
      end
      PB_PRIME: begin
        if (ev.sof) next_pb_st = PB_PLAY;
      end
      PB_PLAY: begin
        if (ev.play_end) next_pb_st = PB_DRAIN;
      end
      PB_DRAIN: begin
        if (buf_empty) next_pb_st = PB_IDLE;
      end
    endcase
    if (!active) next_pb_st = PB_IDLE;
    next_buf_pop = dac_tick && !buf_empty && pb_streaming(pb_st);
    if (next_buf_pop) begin
      next_dac_data = buf_data;
    end else if (dac_tick || pb_waiting(pb_st)) begin
      next_dac_data = BIPOLAR_ZERO_LEVEL;
    end else begin
      next_dac_data = dac_data;
    end
  end

  // Record capture and suspend control
  always_comb begin
    next_capture_en = capture_en;
    if (!active || ev.rec_zero) next_capture_en = 1'b0;
    if (active && ev.rec_sel) next_capture_en = 1'b1;
    next_suspend = idle_done && idle_sync;
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_st <= PB_IDLE;
      buf_pop <= 1'b0;
      dac_data <= BIPOLAR_ZERO_LEVEL;
      capture_en <= 1'b0;
      suspend_indicator <= 1'b0;
      core_rst_n <= 1'b0;
    end else begin
      pb_st <= next_pb_st;
      buf_pop <= next_buf_pop;
      dac_data <= next_dac_data;
      capture_en <= next_capture_en;
      suspend_indicator <= next_suspend;
      core_rst_n <= por_done;
    end
  end

  // Helper: consecutive synchronised idle cycles, saturating
  localparam int RUN_W = $clog2(IDLE_CYCLES + 3);
  localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(IDLE_CYCLES + 1);
  logic [RUN_W-1:0] idle_run;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_run <= '0;
    end else if (!idle_sync) begin
      idle_run <= '0;
    end else if (idle_run != RUN_MAX) begin
      idle_run <= idle_run + RUN_W'(1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_idle_suspended;
    suspend_indicator && idle_sync;
  endsequence
  sequence s_wake_seen;
    suspend_indicator && !idle_sync;
  endsequence

  property p_drain_stops;
    pb_st == PB_DRAIN && buf_empty |=> pb_st == PB_IDLE ##1 dac_data == BIPOLAR_ZERO_LEVEL;
  endproperty
  a_drain_stops: assert property (p_drain_stops) else $error("drain did not stop on empty buffer");

  property p_drain_keeps;
    pb_st == PB_DRAIN && !buf_empty && active |=> pb_st == PB_DRAIN;
  endproperty
  a_drain_keeps: assert property (p_drain_keeps) else $error("playback stopped with samples left");

  property p_capture_cause;
    $rose(capture_en) |-> $past(ev.rec_sel) && $past(active);
  endproperty
  a_capture_cause: assert property (p_capture_cause) else $error("capture began without selection");

  property p_suspend_enter;
    idle_run == RUN_MAX |-> suspend_indicator;
  endproperty
  a_suspend_enter: assert property (p_suspend_enter) else $error("suspend not entered after idle time");

  property p_suspend_early;
    suspend_indicator |-> idle_run == RUN_MAX;
  endproperty
  a_suspend_early: assert property (p_suspend_early) else $error("suspend entered before idle time");

  property p_suspend_hold;
    s_idle_suspended |=> suspend_indicator;
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("suspend indicator dropped while idle");

  property p_wake;
    s_wake_seen |=> !suspend_indicator [*2];
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on bus activity");

  property p_bpz;
    pb_waiting(pb_st) |=> dac_data == BIPOLAR_ZERO_LEVEL && !buf_pop;
  endproperty
  a_bpz: assert property (p_bpz) else $error("output not at bipolar zero while waiting");

  property p_underrun;
    pb_streaming(pb_st) && dac_tick && buf_empty |=> dac_data == BIPOLAR_ZERO_LEVEL && !buf_pop;
  endproperty
  a_underrun: assert property (p_underrun) else $error("output not at bipolar zero on empty buffer");

  property p_unconfigured;
    !active |=> pb_st == PB_IDLE && !capture_en;
  endproperty
  a_unconfigured: assert property (p_unconfigured) else $error("activity kept while unconfigured");

  property p_prime_start;
    pb_st == PB_PRIME && ev.sof && active |=> pb_st == PB_PLAY;
  endproperty
  a_prime_start: assert property (p_prime_start) else $error("playback not started on frame start");

  property p_prime_wait;
    pb_st == PB_PRIME && !ev.sof |=> pb_st != PB_PLAY;
  endproperty
  a_prime_wait: assert property (p_prime_wait) else $error("playback started before frame start");
endmodule

// ---- sim/uas_host_model.sv ----
// Protocol engine and playback buffer model facing the sequencer
`timescale 1ns/1ps
module uas_host_model
  import uas_pkg::*;
(
  input wire logic core_clk,           // Core clock
  input wire logic buf_pop,            // Sample taken by the sequencer
  output uas_ev_s ev,                  // Protocol events
  output logic buf_empty,              // Buffer holds nothing
  output logic [SAMPLE_W-1:0] buf_data // Head sample
);
  int cnt = 0;
  logic [SAMPLE_W-1:0] head = 16'h0000;
  // Empty buffer shows the inverted head, never a stale sample
  assign buf_empty = (cnt == 0);
  assign buf_data = buf_empty ? ~head : head;
  // Advance the head on each pop while the buffer is not empty
  always @(posedge core_clk) begin
    if (buf_pop && cnt > 0) begin
      cnt <= cnt - 1;
      head <= head + 16'h0001;
    end
  end
  // Fill the buffer with n samples counting up from v
  task load(input int n, input logic [SAMPLE_W-1:0] v);
    cnt = n;
    head = v;
  endtask
  // One-cycle event pulse; the host starts recording with the selection pulse
  task pulse(input int k);
    @(posedge core_clk);
    #1 ev[k] = 1'b1;
    @(posedge core_clk);
    #1 ev[k] = 1'b0;
  endtask
  initial ev = '0;
endmodule

// ---- sim/uas_session_seq_tb.sv ----
// Self-checking bench for the audio session sequencer
`timescale 1ns/1ps
module uas_session_seq_tb;
  import uas_pkg::*;
  localparam int IC = 20;
  localparam int PC = 8;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic bus_idle_pin = 1'b0;
  logic dac_tick = 1'b0;
  uas_ev_s ev;
  logic buf_empty, buf_pop, capture_en, suspend_indicator, core_rst_n;
  logic [SAMPLE_W-1:0] buf_data, dac_data;
  int fails = 0;
  int checks = 0;
  uas_session_seq #(.IDLE_CYCLES(IC), .POR_CYCLES(PC)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .bus_idle_pin(bus_idle_pin), .ev(ev), .buf_empty(buf_empty), .buf_data(buf_data),
    .dac_tick(dac_tick), .buf_pop(buf_pop), .dac_data(dac_data), .capture_en(capture_en),
    .suspend_indicator(suspend_indicator), .core_rst_n(core_rst_n));
  uas_host_model host (.core_clk(core_clk), .buf_pop(buf_pop), .ev(ev), .buf_empty(buf_empty),
    .buf_data(buf_data));
  // Single stable core clock for all logic
  initial forever #20 core_clk = ~core_clk;
  // Compare and count
  task check(input string nm, input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One output sample tick; outputs are looked at right after its edge
  task tick(input logic ep, input logic [SAMPLE_W-1:0] ed);
    @(posedge core_clk);
    #1 dac_tick = 1'b1;
    @(posedge core_clk);
    #1 dac_tick = 1'b0;
    check("buf_pop", SAMPLE_W'(buf_pop), SAMPLE_W'(ep));
    check("dac_data", dac_data, ed);
  endtask
  task test_por;
    cyc(PC);
    check("core_rst_n", SAMPLE_W'(core_rst_n), 16'h0000);
    check("dac_data", dac_data, BIPOLAR_ZERO_LEVEL);
    cyc(6);
    check("core_rst_n", SAMPLE_W'(core_rst_n), 16'h0001);
    $display("test_por done");
  endtask
  task test_play;
    host.ev.configured = 1'b1;
    tick(1'b0, BIPOLAR_ZERO_LEVEL);
    host.load(3, 16'h1230);
    host.pulse(3);
    tick(1'b0, BIPOLAR_ZERO_LEVEL);
    host.pulse(4);
    tick(1'b1, 16'h1230);
    host.pulse(2);
    tick(1'b1, 16'h1231);
    tick(1'b1, 16'h1232);
    cyc(3);
    check("dac_data", dac_data, BIPOLAR_ZERO_LEVEL);
    tick(1'b0, BIPOLAR_ZERO_LEVEL);
    $display("test_play done");
  endtask
  task test_rec;
    cyc(2);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0000);
    host.pulse(1);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0001);
    host.pulse(0);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0000);
    $display("test_rec done");
  endtask
  // Underrun in play, then detach drops capture and refuses selection
  task test_under;
    host.load(1, 16'h4560);
    host.pulse(3);
    host.pulse(4);
    tick(1'b1, 16'h4560);
    tick(1'b0, BIPOLAR_ZERO_LEVEL);
    host.pulse(1);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0001);
    host.ev.configured = 1'b0;
    cyc(1);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0000);
    host.pulse(1);
    check("capture_en", SAMPLE_W'(capture_en), 16'h0000);
    check("dac_data", dac_data, BIPOLAR_ZERO_LEVEL);
    $display("test_under done");
  endtask
  task test_susp;
    bus_idle_pin = 1'b1;
    cyc(IC - 4);
    bus_idle_pin = 1'b0;
    cyc(1);
    bus_idle_pin = 1'b1;
    cyc(IC);
    check("suspend_indicator", SAMPLE_W'(suspend_indicator), 16'h0000);
    cyc(5);
    check("suspend_indicator", SAMPLE_W'(suspend_indicator), 16'h0001);
    cyc(30);
    check("suspend_indicator", SAMPLE_W'(suspend_indicator), 16'h0001);
    bus_idle_pin = 1'b0;
    cyc(4);
    check("suspend_indicator", SAMPLE_W'(suspend_indicator), 16'h0000);
    $display("test_susp done");
  endtask
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset for two cycles, then the tests
  initial begin
    cyc(2);
    arst_n = 1'b1;
    test_por;
    test_play;
    test_rec;
    test_under;
    test_susp;
    test_done;
  end
  // Cut a hang short
  initial begin
    #(40 * 3000);
    fails++;
    test_done;
  end
endmodule
